/* fsc_fan_ctrl.sv */
// Fan speed controller: setup sequence, alarm polling and alarm LED latches
// Function
// R01 - Talk to the fan controller only by I2C, this block as bus master.
// R02 - Write the configuration before regulation or alarm monitoring begins.
// R03 - A setup part writes speed; a separate bus part performs I2C transfers.
// R04 - Serial clock comes from the system clock through a programmable prescaler.
// R05 - Speed switch low selects about 2000 RPM, high about 5000 RPM.
// R06 - The fan controller needs 10 to 30 seconds to settle after a change.
// R07 - A detected alarm lights its LED until the clear key turns it off.
// R08 - Alarm bits 0..3 map to max, min, overflow_alarm_a overflow and input-low LEDs.
// R09 - Alarm bits 4 to 7 are ignored; all alarms are zero after reset.
// R10 - Poll the alarm status repeatedly and OR new alarms into the LEDs.
`timescale 1ns/1ps
module fsc_fan_ctrl #(
    parameter int POLL_GAP_CYC = fsc_pkg::POLL_GAP_CYC
) (
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic        speed_sel,
    input  wire logic        alarm_clear,
    input  wire logic [15:0] prescale_div,
    output logic             config_done,
    output logic             link_error,
    output logic             max_level_alarm_led,
    output logic             min_level_alarm_led,
    output logic             overflow_alarm_a_overflow_alarm_led,
    output logic             input_low_alarm_led,
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe
);
    fsc_pkg::fsc_seq_state_t state_reg, state_next;
    logic [1:0]  cfg_idx_reg, cfg_idx_next;
    logic [19:0] gap_reg, gap_next;
    logic [3:0]  leds_reg, leds_next, alarm_new;
    logic        spd_reg, spd_next, cfg_done_reg, cfg_done_next, err_reg, err_next;
    logic        cmd_start, cmd_rw, cmd_busy, cmd_done, cmd_ack_err;
    logic [7:0]  cmd_reg, cmd_data, rd_data;
    logic [15:0] prescale;

    // Register and value of each setup write
    function automatic logic [15:0] cfg_word(input logic [1:0] idx, input logic fast);
        case (idx)
            2'h0:    cfg_word = {fsc_pkg::REG_CONFIG, fsc_pkg::CFG_CLOSED};
            2'h1:    cfg_word = {fsc_pkg::REG_SPEED,
                                 fast ? fsc_pkg::SPEED_5000 : fsc_pkg::SPEED_2000}; // [R05]
            default: cfg_word = {fsc_pkg::REG_ALARM_EN, fsc_pkg::ALARM_EN_MASK};
        endcase
    endfunction : cfg_word

    // A zero prescale selects the standard-mode default rate
    assign prescale = (prescale_div == 16'h0000) ? fsc_pkg::I2C_QTR_CYC : prescale_div; // [R04]

    ////////////////////////////////////////////////////////////////////////////////
    // Bus part: every transfer to the fan controller goes through it
    fsc_i2c_master u_bus (                                                       // [R03]
        .clock       (clock),
        .srst        (srst),
        .prescale    (prescale),
        .cmd_start   (cmd_start),
        .cmd_rw      (cmd_rw),
        .cmd_reg     (cmd_reg),
        .cmd_data    (cmd_data),
        .cmd_busy    (cmd_busy),
        .cmd_done    (cmd_done),
        .cmd_ack_err (cmd_ack_err),
        .rd_data     (rd_data),
        .scl_i       (scl_i),
        .scl_o       (scl_o),
        .scl_oe      (scl_oe),
        .sda_i       (sda_i),
        .sda_o       (sda_o),
        .sda_oe      (sda_oe)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Setup and polling sequencer
    always_comb begin
        state_next    = state_reg;
        cfg_idx_next  = cfg_idx_reg;
        gap_next      = gap_reg;
        spd_next      = spd_reg;
        cfg_done_next = cfg_done_reg;
        err_next      = err_reg;
        cmd_start     = 1'b0;
        cmd_rw        = 1'b0;
        {cmd_reg, cmd_data} = cfg_word(cfg_idx_reg, spd_reg);
        alarm_new     = 4'h0;
        case (state_reg)
            fsc_pkg::SEQ_CFG_ISSUE: begin
                if (cfg_idx_reg == 2'h0) begin
                    spd_next = speed_sel;                                        // [R05]
                end
                if (!cmd_busy) begin
                    cmd_start  = 1'b1;                                           // [R01]
                    state_next = fsc_pkg::SEQ_CFG_WAIT;
                end
            end
            fsc_pkg::SEQ_CFG_WAIT: begin
                if (cmd_done) begin
                    err_next = cmd_ack_err;
                    if (cmd_ack_err) begin
                        cfg_idx_next = 2'h0;
                        state_next   = fsc_pkg::SEQ_CFG_ISSUE;
                    end else if (cfg_idx_reg == fsc_pkg::CFG_LAST_IDX) begin
                        cfg_done_next = 1'b1;                                    // [R02]
                        gap_next      = 20'h00000;
                        state_next    = fsc_pkg::SEQ_GAP;
                    end else begin
                        cfg_idx_next = cfg_idx_reg + 2'h1;
                        state_next   = fsc_pkg::SEQ_CFG_ISSUE;
                    end
                end
            end
            fsc_pkg::SEQ_GAP: begin
                if (speed_sel != spd_reg) begin
                    cfg_done_next = 1'b0;
                    cfg_idx_next  = 2'h0;
                    state_next    = fsc_pkg::SEQ_CFG_ISSUE;
                end else if (gap_reg == 20'(POLL_GAP_CYC - 1)) begin
                    state_next = fsc_pkg::SEQ_POLL_ISSUE;                        // [R10]
                end else begin
                    gap_next = gap_reg + 20'h00001;
                end
            end
            fsc_pkg::SEQ_POLL_ISSUE: begin
                cmd_reg  = fsc_pkg::REG_ALARM_ST;
                cmd_data = 8'h00;
                cmd_rw   = 1'b1;
                if (!cmd_busy) begin
                    cmd_start  = 1'b1;
                    state_next = fsc_pkg::SEQ_POLL_WAIT;
                end
            end
            fsc_pkg::SEQ_POLL_WAIT: begin
                if (cmd_done) begin
                    err_next   = cmd_ack_err;
                    alarm_new  = cmd_ack_err ? 4'h0 : rd_data[3:0];              // [R09]
                    gap_next   = 20'h00000;
                    state_next = fsc_pkg::SEQ_GAP;
                end
            end
            default: state_next = fsc_pkg::SEQ_CFG_ISSUE;
        endcase
        // New alarms win over a clear in the same cycle
        leds_next = (alarm_clear ? 4'h0 : leds_reg) | alarm_new;                 // [R07] [R10]
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state_reg    <= fsc_pkg::SEQ_CFG_ISSUE;
            cfg_idx_reg  <= 2'h0;
            gap_reg      <= 20'h00000;
            spd_reg      <= 1'b0;
            cfg_done_reg <= 1'b0;
            err_reg      <= 1'b0;
            leds_reg     <= fsc_pkg::LED_RST;                                    // [R09]
        end else begin
            state_reg    <= state_next;
            cfg_idx_reg  <= cfg_idx_next;
            gap_reg      <= gap_next;
            spd_reg      <= spd_next;
            cfg_done_reg <= cfg_done_next;
            err_reg      <= err_next;
            leds_reg     <= leds_next;
        end
    end

    assign config_done             = cfg_done_reg;
    assign link_error              = err_reg;
    assign max_level_alarm_led     = leds_reg[0];                            // [R08]
    assign min_level_alarm_led     = leds_reg[1];                            // [R08]
    assign overflow_alarm_a_overflow_alarm_led = leds_reg[2];                            // [R08]
    assign input_low_alarm_led     = leds_reg[3];                            // [R08]

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    sequence cfg_speed_s;
        cmd_start && !cmd_rw && cfg_idx_reg == 2'h1;
    endsequence
    sequence poll_issue_s;
        cmd_start && cmd_rw;
    endsequence
    sequence alarm_seen_s;
        state_reg == fsc_pkg::SEQ_POLL_WAIT && cmd_done && !cmd_ack_err;
    endsequence

    start_when_idle_a: assert property (cmd_start |-> !cmd_busy)              // [R01]
        else $error("transfer started while the bus part was busy");
    cfg_before_poll_a: assert property (poll_issue_s |-> cfg_done_reg)        // [R02]
        else $error("alarm poll issued before setup finished");
    bus_accepts_a: assert property (poll_issue_s |=> cmd_busy ##0 !cmd_done)  // [R03]
        else $error("bus part did not take the poll request");
    speed_value_a: assert property (cfg_speed_s |->
        cmd_data == (spd_reg ? fsc_pkg::SPEED_5000 : fsc_pkg::SPEED_2000))    // [R05]
        else $error("speed write carries the wrong target");
    led_hold_a: assert property (!alarm_clear |=>
        (leds_reg & $past(leds_reg)) == $past(leds_reg))                      // [R07]
        else $error("alarm LED dropped without the clear key");
    led_clear_a: assert property (alarm_clear && !cmd_done |=> leds_reg == 4'h0) // [R07]
        else $error("clear key did not turn the LEDs off");
    alarm_map_a: assert property (alarm_seen_s |=>
        leds_reg == (($past(alarm_clear) ? 4'h0 : $past(leds_reg)) | $past(rd_data[3:0]))) // [R08]
        else $error("alarm bits not merged onto the matching LEDs");
    upper_ignored_a: assert property (alarm_seen_s ##0 (rd_data[3:0] == 4'h0)
        ##0 !alarm_clear |=> $stable(leds_reg))                              // [R09]
        else $error("upper alarm bits changed the LEDs");
    // Cycles spent in the gap state, bounding how long a poll can be put off
    logic [19:0] gap_age_reg, gap_age_next;
    always_comb begin
        gap_age_next = 20'h00000;
        if (state_reg == fsc_pkg::SEQ_GAP) begin
            gap_age_next = gap_age_reg + 20'h00001;
        end
    end
    always_ff @(posedge clock) begin
        if (srst) begin
            gap_age_reg <= 20'h00000;
        end else begin
            gap_age_reg <= gap_age_next;
        end
    end
    poll_repeat_a: assert property (state_reg == fsc_pkg::SEQ_GAP |->             // [R10]
        gap_age_reg < 20'(POLL_GAP_CYC))
        else $error("alarm status not polled again after the gap");
endmodule : fsc_fan_ctrl

/* fsc_pkg.sv */
// Shared constants and state types for the fan speed controller block
package fsc_pkg;
    // Clock rates and derived timing counts
    localparam int          CLK_FREQ_KHZ  = 100000;
    localparam int          I2C_FREQ_KHZ  = 100;
    localparam logic [15:0] I2C_QTR_CYC   = 16'(CLK_FREQ_KHZ / (4 * I2C_FREQ_KHZ));
    localparam int          POLL_GAP_US   = 1000;
    localparam int          POLL_GAP_CYC  = POLL_GAP_US * (CLK_FREQ_KHZ / 1000);
    // Fan controller target address and register map
    localparam logic [6:0]  FAN_I2C_ADDR  = 7'h1B;
    localparam logic [7:0]  REG_SPEED     = 8'h00;
    localparam logic [7:0]  REG_CONFIG    = 8'h02;
    localparam logic [7:0]  REG_ALARM_EN  = 8'h08;
    localparam logic [7:0]  REG_ALARM_ST  = 8'h0A;
    // Values written during setup, the last setup write index and the LED reset value
    localparam logic [7:0]  CFG_CLOSED    = 8'h0A;
    localparam logic [7:0]  SPEED_2000    = 8'h4A;
    localparam logic [7:0]  SPEED_5000    = 8'h1C;
    localparam logic [7:0]  ALARM_EN_MASK = 8'h0F;
    localparam logic [1:0]  CFG_LAST_IDX  = 2'h2;
    localparam logic [3:0]  LED_RST       = 4'h0;

    typedef enum logic [2:0] {
        BUS_IDLE  = 3'b000,
        BUS_START = 3'b001,
        BUS_BIT   = 3'b010,
        BUS_ACK   = 3'b011,
        BUS_STOP  = 3'b100
    } fsc_bus_state_t;

    typedef enum logic [2:0] {
        SEQ_CFG_ISSUE  = 3'b000,
        SEQ_CFG_WAIT   = 3'b001,
        SEQ_GAP        = 3'b010,
        SEQ_POLL_ISSUE = 3'b011,
        SEQ_POLL_WAIT  = 3'b100
    } fsc_seq_state_t;
endpackage : fsc_pkg

/* fsc_i2c_master.sv */
// I2C master that writes or reads one register of the fan controller
`timescale 1ns/1ps
module fsc_i2c_master (
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic [15:0] prescale,
    input  wire logic        cmd_start,
    input  wire logic        cmd_rw,
    input  wire logic [7:0]  cmd_reg,
    input  wire logic [7:0]  cmd_data,
    output logic             cmd_busy,
    output logic             cmd_done,
    output logic             cmd_ack_err,
    output logic [7:0]       rd_data,
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe
);
    fsc_pkg::fsc_bus_state_t state_reg, state_next;
    logic [1:0]  q_reg, q_next, idx_reg, idx_next;
    logic [2:0]  bit_reg, bit_next;
    logic [7:0]  sh_reg, sh_next, rd_reg, rd_next, reg_reg, reg_next, dat_reg, dat_next;
    logic [15:0] cnt_reg, cnt_next;
    logic        rw_reg, rw_next, err_reg, err_next, done_reg, done_next;
    logic        scl_low_reg, scl_low_next, sda_low_reg, sda_low_next;
    logic        tick, step, receiving, last_byte;

    // Byte sent at each position of a transaction
    function automatic logic [7:0] byte_for(input logic [1:0] idx, input logic rw,
                                            input logic [7:0] ra, input logic [7:0] wd);
        case (idx)
            2'h0:    byte_for = {fsc_pkg::FAN_I2C_ADDR, 1'b0};
            2'h1:    byte_for = ra;
            2'h2:    byte_for = rw ? {fsc_pkg::FAN_I2C_ADDR, 1'b1} : wd;
            default: byte_for = 8'hFF;
        endcase
    endfunction : byte_for

    assign tick      = (cnt_reg == 16'h0000);                                    // [R04]
    assign step      = tick && !(state_reg != fsc_pkg::BUS_IDLE && q_reg == 2'h1 && !scl_i);
    assign receiving = rw_reg && (idx_reg == 2'h3);
    assign last_byte = rw_reg ? (idx_reg == 2'h3) : (idx_reg == 2'h2);

    always_comb begin
        state_next = state_reg;
        q_next     = q_reg;
        idx_next   = idx_reg;
        bit_next   = bit_reg;
        sh_next    = sh_reg;
        rd_next    = rd_reg;
        reg_next   = reg_reg;
        dat_next   = dat_reg;
        rw_next    = rw_reg;
        err_next   = err_reg;
        done_next  = 1'b0;
        // Quarter-bit divider, reloaded from the programmable prescale value
        if (state_reg == fsc_pkg::BUS_IDLE) begin
            cnt_next = 16'h0000;
        end else if (tick) begin
            cnt_next = prescale - 16'h0001;                                      // [R04]
        end else begin
            cnt_next = cnt_reg - 16'h0001;
        end
        case (state_reg)
            fsc_pkg::BUS_IDLE: begin
                if (cmd_start) begin
                    rw_next    = cmd_rw;
                    reg_next   = cmd_reg;
                    dat_next   = cmd_data;
                    idx_next   = 2'h0;
                    q_next     = 2'h0;
                    err_next   = 1'b0;
                    cnt_next   = prescale - 16'h0001;
                    state_next = fsc_pkg::BUS_START;                             // [R01]
                end
            end
            fsc_pkg::BUS_START: begin
                if (step) begin
                    q_next = q_reg + 2'h1;
                    if (q_reg == 2'h3) begin
                        bit_next   = 3'h0;
                        sh_next    = byte_for(idx_reg, rw_reg, reg_reg, dat_reg);
                        state_next = fsc_pkg::BUS_BIT;
                    end
                end
            end
            fsc_pkg::BUS_BIT: begin
                if (step) begin
                    q_next = q_reg + 2'h1;
                    if (q_reg == 2'h2 && receiving) begin
                        sh_next = {sh_reg[6:0], sda_i};
                    end
                    if (q_reg == 2'h3) begin
                        if (!receiving) begin
                            sh_next = {sh_reg[6:0], 1'b0};
                        end
                        bit_next = bit_reg + 3'h1;
                        if (bit_reg == 3'h7) begin
                            state_next = fsc_pkg::BUS_ACK;
                        end
                    end
                end
            end
            fsc_pkg::BUS_ACK: begin
                if (step) begin
                    q_next = q_reg + 2'h1;
                    if (q_reg == 2'h2) begin
                        if (receiving) begin
                            rd_next = sh_reg;
                        end else if (sda_i) begin
                            err_next = 1'b1;
                        end
                    end
                    if (q_reg == 2'h3) begin
                        bit_next = 3'h0;
                        idx_next = idx_reg + 2'h1;
                        if (last_byte || err_reg) begin
                            state_next = fsc_pkg::BUS_STOP;
                        end else if (rw_reg && idx_reg == 2'h1) begin
                            state_next = fsc_pkg::BUS_START;
                        end else begin
                            sh_next    = byte_for(idx_next, rw_reg, reg_reg, dat_reg);
                            state_next = fsc_pkg::BUS_BIT;
                        end
                    end
                end
            end
            fsc_pkg::BUS_STOP: begin
                if (step) begin
                    q_next = q_reg + 2'h1;
                    if (q_reg == 2'h3) begin
                        done_next  = 1'b1;
                        state_next = fsc_pkg::BUS_IDLE;
                    end
                end
            end
            default: state_next = fsc_pkg::BUS_IDLE;
        endcase
        // Pin levels follow the next phase so that they leave flip-flops
        scl_low_next = (q_next == 2'h0) || (q_next == 2'h3);
        sda_low_next = 1'b0;
        case (state_next)
            fsc_pkg::BUS_IDLE:  scl_low_next = 1'b0;
            fsc_pkg::BUS_START: sda_low_next = q_next[1];
            fsc_pkg::BUS_BIT:   sda_low_next = !(rw_next && idx_next == 2'h3) && !sh_next[7];
            fsc_pkg::BUS_STOP: begin
                scl_low_next = (q_next == 2'h0);
                sda_low_next = !q_next[1];
            end
            default:            sda_low_next = 1'b0;
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state_reg   <= fsc_pkg::BUS_IDLE;
            q_reg       <= 2'h0;
            idx_reg     <= 2'h0;
            bit_reg     <= 3'h0;
            sh_reg      <= 8'h00;
            rd_reg      <= 8'h00;
            reg_reg     <= 8'h00;
            dat_reg     <= 8'h00;
            cnt_reg     <= 16'h0000;
            rw_reg      <= 1'b0;
            err_reg     <= 1'b0;
            done_reg    <= 1'b0;
            scl_low_reg <= 1'b0;
            sda_low_reg <= 1'b0;
        end else begin
            state_reg   <= state_next;
            q_reg       <= q_next;
            idx_reg     <= idx_next;
            bit_reg     <= bit_next;
            sh_reg      <= sh_next;
            rd_reg      <= rd_next;
            reg_reg     <= reg_next;
            dat_reg     <= dat_next;
            cnt_reg     <= cnt_next;
            rw_reg      <= rw_next;
            err_reg     <= err_next;
            done_reg    <= done_next;
            scl_low_reg <= scl_low_next;
            sda_low_reg <= sda_low_next;
        end
    end

    assign cmd_busy    = (state_reg != fsc_pkg::BUS_IDLE);
    assign cmd_done    = done_reg;
    assign cmd_ack_err = err_reg;
    assign rd_data     = rd_reg;
    assign scl_o       = 1'b0;
    assign scl_oe      = scl_low_reg;
    assign sda_o       = 1'b0;
    assign sda_oe      = sda_low_reg;

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    phase_on_tick_a: assert property ($changed(q_reg) |-> $past(tick))   // [R04]
        else $error("bit phase advanced without a prescale tick");
endmodule : fsc_i2c_master

/* fsc_fan_model.sv */
// Behavioural fan controller target on the serial link
`timescale 1ns/1ps
module fsc_fan_model (
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic [7:0] alarm_status,
    input  wire logic       nack_addr,
    input  wire logic       slow,
    output logic            scl_oe,
    output logic            sda_oe,
    output int              reads
);
    // Speed value is only stored; settling is the fan's own matter
    logic [7:0] regs [0:15];
    logic [7:0] sh, ptr, dout;
    int         cnt, idx;
    logic       rd, ok;
    initial begin
        scl_oe = 0;
        sda_oe = 0;
        reads = 0;
        ok = 0;
        foreach (regs[i]) regs[i] = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////////
    always @(negedge sda) if (scl) begin
        cnt = 0;
        idx = 0;
        rd = 0;
        ok = 1;
    end
    always @(posedge scl) if (ok) begin
        if (cnt < 8) sh = {sh[6:0], sda};
        cnt++;
    end
    always @(negedge scl) if (ok) begin
        if (cnt == 8 && !(rd && idx > 0)) begin
            if (idx == 0) begin
                ok = !nack_addr && sh[7:1] === fsc_pkg::FAN_I2C_ADDR;
                rd = sh[0];
            end else if (idx == 1) ptr = sh;
            else begin
                regs[ptr[3:0]] = sh;
                ptr++;
            end
            sda_oe = ok;
        end else if (cnt == 9) begin
            cnt = 0;
            idx++;
            sda_oe = 0;
            if (rd && idx == 1) begin
                dout = (ptr == 8'h0A) ? alarm_status : regs[ptr[3:0]];
                reads++;
            end
        end
        if (rd && idx == 1) sda_oe = cnt < 8 && !dout[7 - cnt];
        // Stretch the low phase to exercise the master's wait
        if (slow) begin
            scl_oe = 1;
            #300;
            scl_oe = 0;
        end
    end
endmodule : fsc_fan_model

/* tb_fsc_fan_ctrl.sv */
// Self-checking testbench for the fan speed control block
`timescale 1ns/1ps
module tb_fsc_fan_ctrl;
    logic       clock = 0, srst = 1, speed_sel = 0, alarm_clear = 0, nack = 0, slow = 0;
    logic [15:0] prescale = 16'h0004;
    logic [7:0] status = 8'h00;
    logic       config_done, link_error, scl_oe, sda_oe, m_scl_oe, m_sda_oe, scl_o, sda_o;
    logic [3:0] leds;
    wire        scl = (scl_oe ? scl_o : 1'b1) && !m_scl_oe;
    wire        sda = (sda_oe ? sda_o : 1'b1) && !m_sda_oe;
    int         reads, err_total = 0, compares = 0, cycles = 0;
    always #5 clock = !clock;
    fsc_fan_ctrl #(.POLL_GAP_CYC(50)) fsc_fan_ctrl_inst (.clock(clock), .srst(srst),
        .speed_sel(speed_sel), .alarm_clear(alarm_clear), .prescale_div(prescale),
        .config_done(config_done), .link_error(link_error),
        .max_level_alarm_led(leds[0]), .min_level_alarm_led(leds[1]),
        .overflow_alarm_a_overflow_alarm_led(leds[2]), .input_low_alarm_led(leds[3]),
        .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
    fsc_fan_model fsc_fan_model_inst (.scl(scl), .sda(sda), .alarm_status(status),
        .nack_addr(nack), .slow(slow), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe), .reads(reads));
    ////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("Mismatches %0d of %0d compares", err_total, compares);
        if (err_total == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    task automatic wait_sig(input int which, input logic lvl);
        for (int i = 0; i < 9000 && (which ? link_error : config_done) !== lvl; i++) tick(1);
        check({7'h00, which ? link_error : config_done}, {7'h00, lvl});
    endtask : wait_sig
    task automatic wait_reads(input int n);
        int r;
        r = reads + n;
        for (int i = 0; i < 9000 && reads < r; i++) tick(1);
        check({7'h00, reads >= r}, 8'h01);
    endtask : wait_reads
    task automatic pulse_clear;
        alarm_clear = 1;
        tick(1);
        alarm_clear = 0;
    endtask : pulse_clear
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_setup;
        status = 8'hFF;
        wait_sig(0, 1);
        check({4'h0, leds}, 8'h00);
        check(fsc_fan_model_inst.regs[2], fsc_pkg::CFG_CLOSED);
        check(fsc_fan_model_inst.regs[0], fsc_pkg::SPEED_2000);
        check(fsc_fan_model_inst.regs[8], fsc_pkg::ALARM_EN_MASK);
    endtask : t_setup
    task automatic t_map;
        logic [7:0] st [4] = '{8'hF0, 8'hF1, 8'h02, 8'h0C};
        logic [7:0] ex [4] = '{8'h00, 8'h01, 8'h03, 8'h0F};
        status = 8'h00;
        pulse_clear();
        wait_reads(2);
        check({4'h0, leds}, 8'h00);
        foreach (st[i]) begin
            status = st[i];
            wait_reads(2);
            check({4'h0, leds}, ex[i]);
        end
    endtask : t_map
    task automatic t_clear;
        status = 8'h00;
        wait_reads(2);
        check({4'h0, leds}, 8'h0F);
        status = 8'h04;
        pulse_clear();
        wait_reads(2);
        check({4'h0, leds}, 8'h04);
    endtask : t_clear
    task automatic t_prescale;
        int n;
        n = 0;
        @(posedge scl);
        while (scl) begin
            tick(1);
            n++;
        end
        check(8'(n), 8'(2 * prescale));
    endtask : t_prescale
    task automatic t_speed;
        slow = 1;
        speed_sel = 1;
        wait_sig(0, 0);
        wait_sig(0, 1);
        check(fsc_fan_model_inst.regs[0], fsc_pkg::SPEED_5000);
        slow = 0;
    endtask : t_speed
    task automatic t_nack;
        nack = 1;
        wait_sig(1, 1);
        check({4'h0, leds}, 8'h04);
        nack = 0;
        wait_sig(1, 0);
        check({7'h00, config_done}, 8'h01);
        check({7'h00, link_error}, 8'h00);
    endtask : t_nack
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clock) begin
        cycles++;
        if (cycles == 60000) begin
            err_total++;
            print_verdict();
        end
    end
    initial begin
        tick(5);
        check({config_done, link_error, scl_oe, sda_oe, leds}, 8'h00);
        srst = 0;
        t_setup();
        t_map();
        t_clear();
        t_prescale();
        t_speed();
        t_nack();
        print_verdict();
    end
endmodule : tb_fsc_fan_ctrl
